// >>> supervisor_pkg.sv
// constants for the supply supervisor with watchdog
package supervisor_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned CLK_PERIOD_NS = 40;
	// reset stretch interval, nominal figure in ms
	localparam int unsigned RESET_STRETCH_MS = 210;
	localparam int unsigned RESET_STRETCH_CYCLES = RESET_STRETCH_MS * (CLK_HZ / 1000);
	// watchdog interval, nominal figure in ms
	localparam int unsigned WATCHDOG_INTERVAL_MS = 1760;
	localparam longint unsigned WATCHDOG_INTERVAL_CYCLES =
		64'(WATCHDOG_INTERVAL_MS) * 64'(CLK_HZ / 1000);
	// supply fail latency, longest time in us, rounded down
	localparam int unsigned SUPPLY_FAIL_LATENCY_US = 40;
	localparam int unsigned SUPPLY_FAIL_LATENCY_CYCLES =
		SUPPLY_FAIL_LATENCY_US * 1000 / CLK_PERIOD_NS;
	// manual reset glitch rejection, least time in ns, rounded up
	localparam int unsigned MANUAL_REJECT_NS = 100;
	localparam int unsigned MANUAL_REJECT_CYCLES =
		(MANUAL_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// manual reset debounce: must accept a 1 us low, reject 100 ns
	localparam int unsigned MANUAL_MIN_US = 1;
	localparam int unsigned MANUAL_DEBOUNCE_CYCLES = MANUAL_REJECT_CYCLES + 2;
	localparam int unsigned SYNC_STAGES = 3;
	localparam logic RESET_VAL_OUT_N = 1'h0;
	localparam logic MANUAL_IDLE = 1'h1;
endpackage

// >>> pin_sync.sv
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/100ps
module pin_sync #(
	parameter logic INIT = 1'h0
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic pin_in,
	output logic level_out
);
	logic [2:0] stage_q;
	logic level_q;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stage_q <= {3{INIT}};
			level_q <= INIT;
		end else begin
			stage_q <= {stage_q[1:0], pin_in};
			// stage 0 only feeds stage 1
			if (stage_q[1] == stage_q[2]) begin
				level_q <= stage_q[2];
			end
		end
	end

	assign level_out = level_q;
endmodule

// >>> interval_timer.sv
// restartable up-counter that flags when a count is reached
`timescale 1ns/100ps
module interval_timer #(
	parameter int WIDTH = 32
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clear,
	input wire logic run,
	input wire logic [WIDTH-1:0] limit,
	output logic done
);
	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] count_d;
	logic done_q;
	wire logic at_limit;

	assign at_limit = (count_q >= limit);
	assign count_d = clear ? '0 : ((run && !at_limit) ? count_q + 1'b1 : count_q);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			count_q <= '0;
			done_q <= 1'b0;
		end else begin
			count_q <= count_d;
			done_q <= !clear && run && (count_d >= limit);
		end
	end

	assign done = done_q;
endmodule

// >>> supply_supervisor_watchdog_reset.sv
// reset supervisor: supply monitor, manual reset, watchdog, stretch timer
`timescale 1ns/100ps
module supply_supervisor_watchdog_reset #(
	parameter int unsigned STRETCH_CYCLES = supervisor_pkg::RESET_STRETCH_CYCLES,
	parameter longint unsigned WATCHDOG_CYCLES = supervisor_pkg::WATCHDOG_INTERVAL_CYCLES,
	parameter int unsigned DEBOUNCE_CYCLES = supervisor_pkg::MANUAL_DEBOUNCE_CYCLES,
	parameter int TIMER_WIDTH = 32
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic supply_good,
	input wire logic manual_reset_bar_input,
	input wire logic manual_reset_input_driven,
	input wire logic watchdog_kick_input,
	input wire logic watchdog_kick_driven,
	output logic reset_out_n,
	output logic reset_out,
	output logic watchdog_expired
);
	////////////////////////////////////////////////////////////////////////////////
	// state machine
	typedef enum logic [2:0] {
		ST_HOLD = 3'h1,
		ST_STRETCH = 3'h2,
		ST_RUN = 3'h4
	} sup_state_t;

	sup_state_t state_q;
	sup_state_t state_d;

	// one-hot state tests, shared by several sections
	function automatic logic state_is(input sup_state_t cur, input sup_state_t want);
		return (cur == want);
	endfunction

	wire logic in_hold;
	wire logic in_stretch;
	wire logic in_run;
	wire logic next_run;

	assign in_hold = state_is(state_q, ST_HOLD);
	assign in_stretch = state_is(state_q, ST_STRETCH);
	assign in_run = state_is(state_q, ST_RUN);
	assign next_run = state_is(state_d, ST_RUN);

	////////////////////////////////////////////////////////////////////////////////
	// input conditioning
	wire logic manual_raw;
	wire logic manual_floating;
	wire logic manual_sync;
	wire logic kick_sync;
	wire logic kick_driven_sync;
	wire logic supply_sync;

	// undriven manual input reads as the idle high level
	assign manual_floating = !manual_reset_input_driven;
	assign manual_raw = manual_floating ? supervisor_pkg::MANUAL_IDLE
		: manual_reset_bar_input;

	pin_sync #(.INIT(supervisor_pkg::MANUAL_IDLE)) u_sync_manual (
		.clk_sys(clk_sys),
		.srst(srst),
		.pin_in(manual_raw),
		.level_out(manual_sync)
	);

	pin_sync #(.INIT(1'h0)) u_sync_kick (
		.clk_sys(clk_sys),
		.srst(srst),
		.pin_in(watchdog_kick_input),
		.level_out(kick_sync)
	);

	pin_sync #(.INIT(1'h0)) u_sync_kick_drv (
		.clk_sys(clk_sys),
		.srst(srst),
		.pin_in(watchdog_kick_driven),
		.level_out(kick_driven_sync)
	);

	// supply comparator is asynchronous too; adds a few cycles, far below 40 us
	pin_sync #(.INIT(1'h0)) u_sync_supply (
		.clk_sys(clk_sys),
		.srst(srst),
		.pin_in(supply_good),
		.level_out(supply_sync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// manual reset debounce
	logic manual_low_q;
	logic [7:0] deb_cnt_q;
	logic [7:0] deb_cnt_d;
	wire logic deb_mismatch;
	wire logic deb_settled;
	wire logic deb_commit;

	// counts while the levels disagree, restarts once a level is taken
	function automatic logic [7:0] deb_step(input logic differ, input logic full,
		input logic [7:0] cnt);
		logic [7:0] nxt;
		nxt = 8'h00;
		if (differ && !full) begin
			nxt = cnt + 8'h01;
		end
		return nxt;
	endfunction

	// low flag has inverted sense, so equal values mean disagreement
	// new level must persist; shorter lows vanish, a 1 us low always counts
	assign deb_mismatch = (manual_low_q == manual_sync);
	assign deb_settled = (deb_cnt_q >= 8'(DEBOUNCE_CYCLES));
	assign deb_commit = deb_mismatch && deb_settled;
	assign deb_cnt_d = deb_step(deb_mismatch, deb_settled, deb_cnt_q);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			manual_low_q <= 1'b0;
			deb_cnt_q <= 8'h00;
		end else begin
			deb_cnt_q <= deb_cnt_d;
			if (deb_commit) begin
				manual_low_q <= !manual_sync;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// watchdog
	logic kick_prev_q;
	logic kick_driven_prev_q;
	wire logic kick_edge;
	wire logic kick_resume;
	wire logic wd_clear;
	wire logic wd_run;
	wire logic wd_done;
	wire logic [TIMER_WIDTH-1:0] wd_limit;

	// both the kick level and its driven flag are watched for a change
	function automatic logic level_changed(input logic cur, input logic prev);
		return (cur != prev);
	endfunction

	assign wd_limit = TIMER_WIDTH'(WATCHDOG_CYCLES);
	assign kick_edge = kick_driven_sync && level_changed(kick_sync, kick_prev_q);
	assign kick_resume = kick_driven_sync
		&& level_changed(kick_driven_sync, kick_driven_prev_q);
	// counter held clear whenever not running, so release restarts at zero
	assign wd_run = kick_driven_sync && in_run;
	assign wd_clear = kick_edge || kick_resume || !wd_run;

	interval_timer #(.WIDTH(TIMER_WIDTH)) u_watchdog_timer (
		.clk_sys(clk_sys),
		.srst(srst),
		.clear(wd_clear),
		.run(wd_run),
		.limit(wd_limit),
		.done(wd_done)
	);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			kick_prev_q <= 1'b0;
			kick_driven_prev_q <= 1'b0;
		end else begin
			kick_prev_q <= kick_sync;
			kick_driven_prev_q <= kick_driven_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reset stretch
	wire logic hold_src;
	wire logic st_clear;
	wire logic st_done;
	logic wd_cause_q;
	wire logic supply_low;
	wire logic manual_low;
	wire logic [TIMER_WIDTH-1:0] st_limit;

	// sources that hold reset for as long as they last
	assign supply_low = !supply_sync;
	assign manual_low = manual_low_q;
	assign hold_src = supply_low || manual_low;
	assign st_clear = !in_stretch;
	assign st_limit = TIMER_WIDTH'(STRETCH_CYCLES);

	interval_timer #(.WIDTH(TIMER_WIDTH)) u_stretch_timer (
		.clk_sys(clk_sys),
		.srst(srst),
		.clear(st_clear),
		.run(1'b1),
		.limit(st_limit),
		.done(st_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// state transitions
	wire logic go_hold;
	wire logic go_stretch;
	wire logic go_run;
	wire logic wd_fire;
	wire logic cause_set;
	wire logic cause_clear;

	// a holding source always wins over either timer
	assign go_hold = hold_src && !in_hold;
	assign wd_fire = in_run && !hold_src && wd_done;
	assign go_stretch = (in_hold && !hold_src) || wd_fire;
	assign go_run = in_stretch && !hold_src && st_done;
	// a supply or manual hold takes over from a watchdog-started stretch
	assign cause_set = wd_fire;
	assign cause_clear = next_run || go_hold;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_HOLD: begin
				if (go_stretch) begin
					state_d = ST_STRETCH;
				end
			end
			ST_STRETCH: begin
				if (go_hold) begin
					state_d = ST_HOLD;
				end else if (go_run) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (go_hold) begin
					state_d = ST_HOLD;
				end else if (wd_fire) begin
					state_d = ST_STRETCH;
				end
			end
			default: begin
				state_d = ST_HOLD;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= ST_HOLD;
		end else begin
			state_q <= state_d;
		end
	end

	// set wins if a clear falls in the same cycle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wd_cause_q <= 1'b0;
		end else if (cause_set) begin
			wd_cause_q <= 1'b1;
		end else if (cause_clear) begin
			wd_cause_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	logic reset_n_q;
	logic reset_q;
	wire logic reset_any;
	wire logic reset_n_d;
	wire logic reset_d;

	// stretch and hold states both mean reset; next state avoids a cycle of lag
	assign reset_any = !next_run || hold_src;
	// one state feeds both pins, so they can never disagree
	assign reset_n_d = !reset_any;
	assign reset_d = reset_any;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reset_n_q <= supervisor_pkg::RESET_VAL_OUT_N;
			reset_q <= !supervisor_pkg::RESET_VAL_OUT_N;
		end else begin
			reset_n_q <= reset_n_d;
			reset_q <= reset_d;
		end
	end

	assign reset_out_n = reset_n_q;
	assign reset_out = reset_q;
	assign watchdog_expired = wd_cause_q;
endmodule

// >>> supervisor_checker.sv
// concurrent checks on the supervisor ports
`timescale 1ns/100ps
module supervisor_checker #(
	parameter int unsigned STRETCH_CYCLES = 50,
	parameter longint unsigned WATCHDOG_CYCLES = 200
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic supply_good,
	input wire logic manual_reset_bar_input,
	input wire logic manual_reset_input_driven,
	input wire logic watchdog_kick_input,
	input wire logic watchdog_kick_driven,
	input wire logic reset_out_n,
	input wire logic reset_out,
	input wire logic watchdog_expired
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	longint clr_q;
	longint low_q;
	longint age_q;
	logic kick_q;
	wire logic calm = supply_good && (manual_reset_bar_input || !manual_reset_input_driven);
	// raw pins, so margins absorb synchroniser and debounce lag
	always_ff @(posedge clk_sys) begin
		kick_q <= watchdog_kick_input;
		clr_q <= (srst || !calm) ? 0 : clr_q + 1;
		low_q <= (srst || reset_out_n) ? 0 : low_q + 1;
		age_q <= (srst || !reset_out_n || !watchdog_kick_driven
			|| kick_q != watchdog_kick_input) ? 0 : age_q + 1;
	end
	AST_COMPL: assert property (reset_out_n != reset_out)
		else $error("outputs not complementary");
	AST_SUP: assert property (!supply_good [*8] |-> !reset_out_n)
		else $error("no reset on supply loss");
	AST_MAN: assert property ((manual_reset_input_driven && !manual_reset_bar_input)
		[*8] |-> ##4 !reset_out_n) else $error("no reset on manual low");
	AST_FLOAT: assert property (!watchdog_kick_driven [*8] |-> !$rose(watchdog_expired))
		else $error("expiry while kick floats");
	AST_WDRST: assert property ($rose(watchdog_expired) |-> ##[0:2] !reset_out_n)
		else $error("expiry without reset");
	AST_KMAX: assert property (age_q <= WATCHDOG_CYCLES + 12)
		else $error("watchdog overdue");
	AST_KMIN: assert property ($rose(watchdog_expired) |-> age_q + 8 >= WATCHDOG_CYCLES)
		else $error("watchdog expired early");
	AST_STRMIN: assert property ($rose(reset_out_n) |-> low_q >= STRETCH_CYCLES)
		else $error("reset released early");
	AST_STRMAX: assert property (clr_q == STRETCH_CYCLES + 20 |-> reset_out_n)
		else $error("reset held too long");
	C_WD: cover property ($rose(watchdog_expired));
	C_SUP: cover property (!supply_good ##1 supply_good);
	C_REL: cover property ($rose(reset_out_n));
	C_MAN: cover property (manual_reset_input_driven && !manual_reset_bar_input && !reset_out_n);
endmodule
////////////////////////////////////////
bind supply_supervisor_watchdog_reset supervisor_checker #(.STRETCH_CYCLES(STRETCH_CYCLES),
	.WATCHDOG_CYCLES(WATCHDOG_CYCLES)) chk (.clk_sys, .srst, .supply_good,
	.manual_reset_bar_input, .manual_reset_input_driven, .watchdog_kick_input,
	.watchdog_kick_driven, .reset_out_n, .reset_out, .watchdog_expired);

// >>> cpu_model.sv
// processor model driving the watchdog kick
`timescale 1ns/100ps
module cpu_model (
	input wire logic clk_sys,
	input wire logic reset_out_n,
	input wire logic [1:0] mode,
	output logic kick,
	output logic kick_driven
);
	logic lvl_q = 1'h0;
	logic [1:0] cnt_q = 2'h0;
	// released line shows the inverse of its last level
	assign kick = (mode == 2'h2) ? ~lvl_q : lvl_q;
	assign kick_driven = mode != 2'h2;
	// no kicks while held in reset
	always @(posedge clk_sys) begin
		cnt_q <= cnt_q + 2'h1;
		if (mode == 2'h1 && reset_out_n && cnt_q == 2'h3) begin
			lvl_q <= ~lvl_q;
		end
	end
endmodule

// >>> supply_supervisor_watchdog_reset_tb_top.sv
// self-checking bench for the supervisor
`timescale 1ns/100ps
module supply_supervisor_watchdog_reset_tb_top;
	localparam int S = 50;
	localparam int W = 200;
	logic clk_sys = 1'h0;
	logic srst = 1'h1;
	logic sup = 1'h0;
	logic mr_n = 1'h1;
	logic mr_drv = 1'h1;
	logic [1:0] mode = 2'h1;
	logic kick, kd, rn, ro, wd;
	int errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int n;
	initial forever #20 clk_sys = ~clk_sys;
	supply_supervisor_watchdog_reset #(.STRETCH_CYCLES(S), .WATCHDOG_CYCLES(W)) dut (
		.clk_sys, .srst, .supply_good(sup), .manual_reset_bar_input(mr_n),
		.manual_reset_input_driven(mr_drv), .watchdog_kick_input(kick),
		.watchdog_kick_driven(kd), .reset_out_n(rn), .reset_out(ro), .watchdog_expired(wd));
	cpu_model cpu (.clk_sys, .reset_out_n(rn), .mode, .kick, .kick_driven(kd));
	////////////////////////////////////////
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input logic [1:0] got, input logic [1:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// waits for the reset level, judging how long it took
	task automatic win(input logic v, input int lo, input int hi);
		n = 0;
		while (rn !== v && n <= hi) begin
			tick(1);
			n++;
		end
		chk({rn, n >= lo && n <= hi}, {v, 1'h1});
		chk({1'h0, ro}, {1'h0, ~v});
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic t_supply;
		tick(20);
		chk({1'h0, rn}, 2'h0);
		sup = 1'h1;
		win(1'h1, S, S + 15);
		sup = 1'h0;
		win(1'h0, 0, 8);
		tick(30);
		chk({1'h0, rn}, 2'h0);
		sup = 1'h1;
		win(1'h1, S, S + 15);
		$display("supply done");
	endtask
	task automatic t_manual;
		mr_n = 1'h0;
		tick(2);
		mr_n = 1'h1;
		tick(20);
		chk({1'h0, rn}, 2'h1);
		mr_n = 1'h0;
		win(1'h0, 4, 14);
		tick(20);
		chk({1'h0, rn}, 2'h0);
		mr_n = 1'h1;
		win(1'h1, S, S + 15);
		mr_drv = 1'h0;
		mr_n = 1'h0;
		tick(30);
		chk({1'h0, rn}, 2'h1);
		mr_drv = 1'h1;
		mr_n = 1'h1;
		$display("manual done");
	endtask
	task automatic t_wd;
		mode = 2'h0;
		win(1'h0, W - 60, W + 12);
		tick(2);
		chk({1'h0, wd}, 2'h1);
		win(1'h1, S - 4, S + 15);
		win(1'h0, W - 4, W + 12);
		win(1'h1, S - 2, S + 15);
		mode = 2'h1;
		tick(3 * W);
		chk({1'h0, rn}, 2'h1);
		mode = 2'h2;
		tick(3 * W);
		chk({1'h0, rn}, 2'h1);
		mode = 2'h0;
		win(1'h0, W - 2, W + 12);
		win(1'h1, S - 2, S + 15);
		mode = 2'h1;
		$display("watchdog done");
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		tick(10);
		srst = 1'h0;
		t_supply();
		t_manual();
		t_wd();
		wrap_up();
	end
endmodule
